// >>> hw/drive_port_pkg.sv
// Constants and types for the drive select and control port
package drive_port_pkg;
  // ===========================================================
  // Widths
  localparam int UNIT_COUNT       = 4;
  localparam int HEAD_BITS        = 4;
  localparam int SYNC_STAGES      = 3;
  localparam int CTRL_BITS        = 12;
  // ===========================================================
  // Control input bit positions in the sampled vector
  localparam int POS_SEL_LO       = 0;
  localparam int POS_HEAD_LO      = 4;
  localparam int POS_WGATE        = 8;
  localparam int POS_STEP         = 9;
  localparam int POS_DIR          = 10;
  localparam int POS_RECOV        = 11;
  // ===========================================================
  // Reset values
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 12'hFFF;
  localparam logic [1:0]           UNIT_RESET = 2'h0;
  // ===========================================================
  // Startup sequence states
  typedef enum logic [1:0] {
    ST_RESET  = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } start_state_t;
endpackage

// >>> hw/sync_if.sv
// Carrier between the pin synchroniser and the port logic
`timescale 1ns/1ns
interface sync_if;
  logic [drive_port_pkg::CTRL_BITS-1:0] raw;
  logic [drive_port_pkg::CTRL_BITS-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// >>> hw/pin_sync.sv
// Three-stage synchroniser with agreement filter for cable inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = drive_port_pkg::CTRL_BITS
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  // Pins in, clean levels out
  sync_if.sync      pins
);
  import drive_port_pkg::*;

  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
  logic [WIDTH-1:0] clean_next;

  // Stage resets and the carrier are sized to the control vector
  if (WIDTH != CTRL_BITS) begin : g_width_check
    $error("pin_sync width must match the control vector");
  end

  // ===========================================================
  // Filter: take a change once stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      clean_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : clean_reg[i];
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg    <= CTRL_RESET;
      s2_reg    <= CTRL_RESET;
      s3_reg    <= CTRL_RESET;
      clean_reg <= CTRL_RESET;
    end else begin
      s1_reg    <= pins.raw;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      clean_reg <= clean_next;
    end
  end

  assign pins.clean = clean_reg;
endmodule

// >>> hw/drive_select_and_control_port.sv
// Drive-side unit select, status gating and write fault port
`timescale 1ns/1ns
module drive_select_and_control_port #(
  parameter int UNITS = drive_port_pkg::UNIT_COUNT
) (
  // Clock and reset
  input  wire logic                                clk_sys_i,
  input  wire logic                                sys_rst_i,
  // Cable control inputs, active low
  input  wire logic [drive_port_pkg::UNIT_COUNT-1:0] unit_sel_n_i,
  input  wire logic [drive_port_pkg::HEAD_BITS-1:0]  head_sel_n_i,
  input  wire logic                                write_gate_n_i,
  input  wire logic                                step_n_i,
  input  wire logic                                dir_in_n_i,
  input  wire logic                                recovery_n_i,
  // Configuration jumpers
  input  wire logic [1:0]                          config_shunt_unit_i,
  input  wire logic                                config_shunt_radial_i,
  input  wire logic                                fault_latch_jumper_i,
  input  wire logic                                config_shunt_clr_i,
  input  wire logic                                supply_fault_jumper_i,
  input  wire logic                                config_shunt_recov_i,
  // Internal drive status, active high
  input  wire logic                                seek_done_i,
  input  wire logic                                track_zero_i,
  input  wire logic                                index_i,
  input  wire logic                                ready_i,
  input  wire logic                                fault_cause_i,
  input  wire logic                                supply_unsafe_condition_i,
  // Cable status outputs, open collector, oe low drives
  output logic                                     seek_done_oe_n_o,
  output logic                                     track_zero_oe_n_o,
  output logic                                     write_fault_oe_n_o,
  output logic                                     index_oe_n_o,
  output logic                                     ready_oe_n_o,
  output logic                                     selected_oe_n_o,
  // Decoded controls to drive internals
  output logic                                     selected_o,
  output logic [drive_port_pkg::HEAD_BITS-1:0]     head_num_o,
  output logic                                     write_enable_o,
  output logic                                     read_enable_o,
  output logic                                     step_o,
  output logic                                     dir_in_o,
  output logic                                     microstep_o,
  output logic                                     activity_led_o,
  output logic                                     write_fault_o
);
  import drive_port_pkg::*;

  if (UNITS != UNIT_COUNT) begin : g_unit_check
    $error("unit count must be four");
  end

  // ===========================================================
  // Input synchronisation
  sync_if cable ();
  logic [CTRL_BITS-1:0] c;

  assign cable.raw = {recovery_n_i, dir_in_n_i, step_n_i, write_gate_n_i,
                      head_sel_n_i, unit_sel_n_i};

  pin_sync #(.WIDTH(CTRL_BITS)) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .pins      (cable)
  );
  assign c = cable.clean;

  // ===========================================================
  // Jumper capture after reset release
  start_state_t st_reg, st_next;
  logic [1:0]   unit_reg, unit_next;
  logic         radial_reg, radial_next;
  logic         latch_reg, latch_next;
  logic         clr_reg, clr_next;
  logic         supply_reg, supply_next;
  logic         recov_reg, recov_next;

  always_comb begin
    st_next     = st_reg;
    unit_next   = unit_reg;
    radial_next = radial_reg;
    latch_next  = latch_reg;
    clr_next    = clr_reg;
    supply_next = supply_reg;
    recov_next  = recov_reg;
    case (st_reg)
      ST_RESET: begin
        st_next = ST_SETTLE;
      end
      ST_SETTLE: begin
        unit_next   = config_shunt_unit_i;
        radial_next = config_shunt_radial_i;
        latch_next  = fault_latch_jumper_i;
        clr_next    = config_shunt_clr_i;
        supply_next = supply_fault_jumper_i;
        recov_next  = config_shunt_recov_i;
        st_next     = ST_RUN;
      end
      ST_RUN: begin
        st_next = ST_RUN;
      end
      default: begin
        st_next = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg     <= ST_RESET;
      unit_reg   <= UNIT_RESET;
      radial_reg <= 1'b0;
      latch_reg  <= 1'b0;
      clr_reg    <= 1'b0;
      supply_reg <= 1'b0;
      recov_reg  <= 1'b0;
    end else begin
      st_reg     <= st_next;
      unit_reg   <= unit_next;
      radial_reg <= radial_next;
      latch_reg  <= latch_next;
      clr_reg    <= clr_next;
      supply_reg <= supply_next;
      recov_reg  <= recov_next;
    end
  end

  // ===========================================================
  // Selection and control decode
  logic run, sel, wgate, fault_now;
  logic latched_reg, latched_next;
  logic [HEAD_BITS-1:0] head_reg, head_next;

  assign run = (st_reg == ST_RUN);
  // Only the jumpered select line counts; radial forces selection
  assign sel = run & (radial_reg |
               ~c[POS_SEL_LO + unit_reg]);
  assign wgate = sel & ~c[POS_WGATE];

  // Head code only follows the cable while not writing
  always_comb begin
    head_next = head_reg;
    if (sel && !wgate) begin
      head_next = ~c[POS_HEAD_LO +: HEAD_BITS];
    end
  end

  // Fault source: write path fault, or unsafe supply when jumpered
  always_comb begin
    fault_now = (wgate & fault_cause_i) |
                (supply_reg & supply_unsafe_condition_i);
    latched_next = latched_reg;
    if (!latch_reg || !run) begin
      latched_next = 1'b0;
    end else if (fault_now) begin
      latched_next = 1'b1;
    end else if (clr_reg && !sel && !fault_cause_i) begin
      latched_next = 1'b0;
    end
    // Without the clear jumper only reset drops the latch
  end

  // ===========================================================
  // Output registers
  logic wf;
  assign wf = fault_now | latched_reg;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latched_reg        <= 1'b0;
      head_reg           <= '0;
      seek_done_oe_n_o   <= 1'b1;
      track_zero_oe_n_o  <= 1'b1;
      write_fault_oe_n_o <= 1'b1;
      index_oe_n_o       <= 1'b1;
      ready_oe_n_o       <= 1'b1;
      selected_oe_n_o    <= 1'b1;
      selected_o         <= 1'b0;
      head_num_o         <= '0;
      write_enable_o     <= 1'b0;
      read_enable_o      <= 1'b0;
      step_o             <= 1'b0;
      dir_in_o           <= 1'b0;
      microstep_o        <= 1'b0;
      activity_led_o     <= 1'b0;
      write_fault_o      <= 1'b0;
    end else begin
      latched_reg        <= latched_next;
      head_reg           <= head_next;
      seek_done_oe_n_o   <= ~(sel & seek_done_i);
      track_zero_oe_n_o  <= ~(sel & track_zero_i);
      write_fault_oe_n_o <= ~(sel & wf);
      index_oe_n_o       <= ~(sel & index_i);
      ready_oe_n_o       <= ~(sel & ready_i);
      selected_oe_n_o    <= ~sel;
      selected_o         <= sel;
      head_num_o         <= head_next;
      write_enable_o     <= wgate & ~wf;
      read_enable_o      <= sel & ~wgate;
      step_o             <= sel & ~wgate & ~c[POS_STEP];
      dir_in_o           <= sel & ~c[POS_DIR];
      microstep_o        <= sel & recov_reg & ~c[POS_RECOV];
      activity_led_o     <= sel & ~radial_reg;
      write_fault_o      <= wf;
    end
  end
endmodule

// >>> verif/drive_port_properties.sv
// Assertions on the drive select and control port pins
`timescale 1ns/1ns
module drive_port_properties (
  // Clock, reset and cable inputs
  input wire logic       clk_sys_i, sys_rst_i, write_gate_n_i,
  input wire logic [3:0] head_sel_n_i,
  // Jumpers and internal status
  input wire logic       config_shunt_radial_i, fault_latch_jumper_i,
  input wire logic       config_shunt_clr_i, supply_fault_jumper_i,
  input wire logic       config_shunt_recov_i, fault_cause_i,
  input wire logic       supply_unsafe_condition_i,
  // Outputs under watch
  input wire logic       seek_done_oe_n_o, track_zero_oe_n_o,
  input wire logic       write_fault_oe_n_o, index_oe_n_o, ready_oe_n_o,
  input wire logic       selected_oe_n_o, selected_o, write_enable_o,
  input wire logic       read_enable_o, step_o, microstep_o,
  input wire logic       activity_led_o, write_fault_o,
  input wire logic [3:0] head_num_o
);
  logic [2:0] up_reg;
  logic [3:0] gh_reg;
  logic       up;
  // Cycles since reset and cycles of write gate high
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      up_reg <= 3'h0;
      gh_reg <= 4'h0;
    end else begin
      up_reg <= (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
      gh_reg <= !write_gate_n_i ? 4'h0 :
                (gh_reg == 4'hf) ? gh_reg : gh_reg + 4'h1;
    end
  end
  assign up = (up_reg == 3'h7);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  status_gated_a: assert property (
    !selected_o && !$past(selected_o) |-> &{seek_done_oe_n_o,
    track_zero_oe_n_o, write_fault_oe_n_o, index_oe_n_o, ready_oe_n_o,
    selected_oe_n_o}) else $error("status driven while unselected");
  radial_sel_a: assert property (
    up && config_shunt_radial_i |-> selected_o)
    else $error("radial drive not selected");
  radial_led_a: assert property (
    up && config_shunt_radial_i |-> !activity_led_o)
    else $error("activity light on in radial mode");
  std_fault_a: assert property (
    up && !fault_latch_jumper_i && !supply_fault_jumper_i &&
    gh_reg >= 4'h8 |-> !write_fault_o) else $error("fault without gate");
  latch_hold_a: assert property (
    up && fault_latch_jumper_i && !config_shunt_clr_i && write_fault_o
    |=> write_fault_o) else $error("latched fault dropped");
  deselect_clr_a: assert property (
    (up && fault_latch_jumper_i && config_shunt_clr_i &&
    !supply_fault_jumper_i && !selected_o && !fault_cause_i)[*3]
    |-> !write_fault_o) else $error("fault kept after deselect");
  supply_a: assert property (
    up && selected_o && supply_fault_jumper_i && supply_unsafe_condition_i
    |=> write_fault_o) else $error("unsafe supply not reported");
  recov_a: assert property (
    up && !config_shunt_recov_i |-> !microstep_o)
    else $error("microstep without option");
  head_a: assert property (
    (selected_o && write_gate_n_i && $stable(head_sel_n_i))[*8]
    |-> head_num_o == ~head_sel_n_i) else $error("head number wrong");
  rw_excl_a: assert property (
    write_enable_o |-> !read_enable_o && selected_o)
    else $error("write and read together");
  step_a: assert property (
    step_o |-> selected_o && read_enable_o) else $error("step not gated");
endmodule
bind drive_select_and_control_port drive_port_properties chk (
  .clk_sys_i                 (clk_sys_i),
  .sys_rst_i                 (sys_rst_i),
  .write_gate_n_i            (write_gate_n_i),
  .head_sel_n_i              (head_sel_n_i),
  .config_shunt_radial_i     (config_shunt_radial_i),
  .fault_latch_jumper_i      (fault_latch_jumper_i),
  .config_shunt_clr_i        (config_shunt_clr_i),
  .supply_fault_jumper_i     (supply_fault_jumper_i),
  .config_shunt_recov_i      (config_shunt_recov_i),
  .fault_cause_i             (fault_cause_i),
  .supply_unsafe_condition_i (supply_unsafe_condition_i),
  .seek_done_oe_n_o          (seek_done_oe_n_o),
  .track_zero_oe_n_o         (track_zero_oe_n_o),
  .write_fault_oe_n_o        (write_fault_oe_n_o),
  .index_oe_n_o              (index_oe_n_o),
  .ready_oe_n_o              (ready_oe_n_o),
  .selected_oe_n_o           (selected_oe_n_o),
  .selected_o                (selected_o),
  .write_enable_o            (write_enable_o),
  .read_enable_o             (read_enable_o),
  .step_o                    (step_o),
  .microstep_o               (microstep_o),
  .activity_led_o            (activity_led_o),
  .write_fault_o             (write_fault_o),
  .head_num_o                (head_num_o)
);

// >>> verif/host_ctrl_model.sv
// Behavioural disc controller driving the control cable
`timescale 1ns/1ns
module host_ctrl_model (
  input  wire logic clk_sys_i,
  output logic [3:0] unit_sel_n_o,
  output logic [3:0] head_sel_n_o,
  output logic       write_gate_n_o,
  output logic       step_n_o,
  output logic       dir_in_n_o,
  output logic       recovery_n_o
);
  // Terminated lines idle high
  initial begin
    unit_sel_n_o = 4'hf;
    head_sel_n_o = 4'hf;
    {write_gate_n_o, step_n_o, dir_in_n_o, recovery_n_o} = 4'hf;
  end
  task automatic tick;
    @(posedge clk_sys_i);
    #2;
  endtask
  // One select line at most, negative releases all
  task automatic sel(input int u);
    tick;
    unit_sel_n_o = (u < 0) ? 4'hf : ~(4'h1 << u);
  endtask
  task automatic gate(input logic on);
    tick;
    write_gate_n_o = !on;
  endtask
  // Head code moves only while not writing
  task automatic head(input logic [3:0] h);
    tick;
    if (write_gate_n_o) head_sel_n_o = ~h;
  endtask
  task automatic ctl(input logic s, d, r);
    tick;
    {step_n_o, dir_in_n_o, recovery_n_o} = {!s, !d, !r};
  endtask
endmodule

// >>> verif/test_drive_select_and_control_port.sv
// Self-checking bench for the drive select and control port
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module test_drive_select_and_control_port;
  import drive_port_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [3:0] usel_n, hsel_n, hnum;
  logic       wg_n, st_n, dir_n, rec_n;
  logic [1:0] unit = 2'h0;
  logic       rad = 0, lat = 0, clr = 0, sup = 0, rcv = 0;
  logic       sd = 1, tz = 0, idx = 1, rdy = 1, cause = 0, unsafe = 0;
  logic [5:0] oe_n;
  logic       sel, we, re, stp, dir, mstep, led, wf;
  int         errors = 0, checked = 0, cyc = 0;
  host_ctrl_model host (.clk_sys_i(clk_sys_i), .unit_sel_n_o(usel_n),
    .head_sel_n_o(hsel_n), .write_gate_n_o(wg_n), .step_n_o(st_n),
    .dir_in_n_o(dir_n), .recovery_n_o(rec_n));
  drive_select_and_control_port dut (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .unit_sel_n_i(usel_n), .head_sel_n_i(hsel_n),
    .write_gate_n_i(wg_n), .step_n_i(st_n), .dir_in_n_i(dir_n),
    .recovery_n_i(rec_n), .config_shunt_unit_i(unit),
    .config_shunt_radial_i(rad), .fault_latch_jumper_i(lat),
    .config_shunt_clr_i(clr), .supply_fault_jumper_i(sup),
    .config_shunt_recov_i(rcv), .seek_done_i(sd), .track_zero_i(tz),
    .index_i(idx), .ready_i(rdy), .fault_cause_i(cause),
    .supply_unsafe_condition_i(unsafe), .seek_done_oe_n_o(oe_n[5]),
    .track_zero_oe_n_o(oe_n[4]), .write_fault_oe_n_o(oe_n[3]),
    .index_oe_n_o(oe_n[2]), .ready_oe_n_o(oe_n[1]),
    .selected_oe_n_o(oe_n[0]), .selected_o(sel), .head_num_o(hnum),
    .write_enable_o(we), .read_enable_o(re), .step_o(stp),
    .dir_in_o(dir), .microstep_o(mstep), .activity_led_o(led),
    .write_fault_o(wf));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  // boot changes the jumpers only while reset is held
  task automatic boot(input logic [1:0] u, input logic r, l, c, s, v);
    wt(1);
    sys_rst_i = 1'b1;
    unit = u;
    rad = r;
    lat = l;
    clr = c;
    sup = s;
    rcv = v;
    wt(5);
    sys_rst_i = 1'b0;
    wt(8);
  endtask
  initial begin
    boot(2'h1, 0, 0, 0, 0, 0);
    `CHK({sel, oe_n}, 7'h3f)
    for (int k = 0; k < 4; k++) begin
      boot(2'(k), 0, 0, 0, 0, 0);
      for (int u = 0; u < 4; u++) begin
        host.sel(u);
        wt(8);
        `CHK(sel, (u == k))
        `CHK(oe_n, (u == k) ? 6'h18 : 6'h3f)
      end
    end
    // Every status line follows its source while selected
    sd = 1'b0;
    tz = 1'b1;
    idx = 1'b0;
    rdy = 1'b0;
    wt(2);
    `CHK({oe_n, led}, 7'h5d)
    $display("test select finished");
    for (int h = 0; h < 16; h += 5) begin
      host.head(4'(h));
      wt(8);
      `CHK(hnum, 4'(h))
    end
    host.ctl(1, 1, 1);
    wt(8);
    `CHK({we, re, stp, dir, mstep}, 5'h0e)
    host.gate(1);
    wt(8);
    `CHK({we, re, stp}, 3'h4)
    cause = 1'b1;
    wt(2);
    `CHK({wf, oe_n[3], we}, 3'h4)
    host.gate(0);
    wt(8);
    `CHK(wf, 1'b0)
    host.ctl(0, 0, 0);
    host.sel(-1);
    host.gate(1);
    wt(8);
    `CHK({sel, we, wf, oe_n}, 9'h03f)
    cause = 1'b0;
    host.gate(0);
    $display("test write gate finished");
    for (int c = 0; c < 2; c++) begin
      boot(2'h0, 0, 1, c[0], 0, 0);
      host.sel(0);
      host.gate(1);
      wt(8);
      cause = 1'b1;
      wt(2);
      cause = 1'b0;
      host.gate(0);
      wt(8);
      `CHK(wf, 1'b1)
      host.sel(-1);
      wt(8);
      `CHK({wf, oe_n[3]}, {!c[0], 1'b1})
    end
    $display("test latch finished");
    boot(2'h0, 0, 0, 0, 1, 1);
    host.sel(0);
    wt(8);
    unsafe = 1'b1;
    wt(2);
    `CHK(wf, 1'b1)
    unsafe = 1'b0;
    host.ctl(0, 0, 1);
    wt(8);
    `CHK({wf, mstep}, 2'h1)
    host.ctl(0, 0, 0);
    boot(2'h2, 1, 0, 0, 0, 0);
    host.sel(-1);
    host.gate(1);
    wt(8);
    `CHK({sel, led, we}, 3'h5)
    // Jumper moved without reset is ignored
    rad = 1'b0;
    wt(4);
    `CHK({sel, led}, 2'h2)
    $display("test options finished");
    results();
  end
endmodule
